// ===== src/osw_pkg.sv
// Behaviour
// - Outputs five, six on if pin or command
// - Held in reset, drivers off, below threshold
// - Status shifts out while command shifts in
// - Status one for any fault, zero otherwise
// - Sixteen bits: status then echo first byte
// - Last byte received applied at select rise
// - Overtemp turns that output off at once
// - Overtemp shutdown reads one in status
// - Output restarts when overtemp clears, if commanded
// - Overvoltage forces all off, then restores
// - Serial input sampled on falling clock edges
// - Select fall loads status, enables output
// - Status shifted out msb first on rising
// - Select high: clock ignored, output released
package osw_pkg;
  localparam int NUM_OUT = 8;
  localparam int PWM_FIVE_IDX = 4;
  localparam int PWM_SIX_IDX = 5;
  localparam int FRAME_BITS = 8;
  localparam logic [7:0] CMD_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [3:0] CNT_FULL = 4'h8;
  localparam logic [3:0] CNT_LAST = 4'h7;
  // Host side limits, informative only
  localparam int PWM_MAX_HZ = 2000;
  localparam int WRITE_GAP_US = 300;
  localparam int CLK_HZ = 10000000;
  localparam int WRITE_GAP_CYC = (WRITE_GAP_US * (CLK_HZ / 1000000)) + 1;
  // Synchroniser bundle layout and idle values
  localparam int SYNC_W = 29;
  localparam int SY_CS = 0;
  localparam int SY_EN = 1;
  localparam int SY_PWM5 = 2;
  localparam int SY_PWM6 = 3;
  localparam int SY_OV = 4;
  localparam int SY_OL = 5;
  localparam int SY_SH = 13;
  localparam int SY_OT = 21;
  localparam logic [28:0] SYNC_INIT = 29'h0000001;
endpackage : osw_pkg

// ===== src/osw_sync3.sv
`timescale 1ns/100ps
module osw_sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk, // Destination clock
  input wire logic rst_b, // Async reset, active low
  input wire logic [W-1:0] din, // Asynchronous inputs
  output logic [W-1:0] dout // Filtered synchronous copy
);
  if (W < 1)
  begin : g_bad_w
    $error("osw_sync3 needs at least one bit");
  end

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] filt;
  } osw_sync_t;

  osw_sync_t st_q, st_d;

  ////////////////////////////////////////////////////////////////
  // Three stages; a bit moves only once stages two and three agree
  always_comb
  begin
    st_d = st_q;
    st_d.s1 = din;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < W; i++)
    begin
      if (st_q.s2[i] == st_q.s3[i])
      begin
        st_d.filt[i] = st_q.s3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q <= {INIT, INIT, INIT, INIT};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign dout = st_q.filt;
endmodule : osw_sync3

// ===== src/osw_fault_logic.sv
`timescale 1ns/100ps
module osw_fault_logic #(
  parameter int N_OUT = osw_pkg::NUM_OUT
) (
  input wire logic clk, // 10 MHz core clock
  input wire logic rst_b, // Power-on reset, active low
  input wire logic sclk, // Serial clock from host
  input wire logic cs_b, // Chip select, active low
  input wire logic serial_command_in, // Serial command data
  output logic serial_data_out, // Serial status data
  output logic serial_data_out_oe, // High while driving data out
  input wire logic enable, // Device enable
  input wire logic direct_pwm_input_five, // Direct drive, output five
  input wire logic direct_pwm_input_six, // Direct drive, output six
  input wire logic power_supply_over_voltage, // Supply overvoltage flag
  input wire logic [7:0] over_temp, // Per-output overtemp flag
  input wire logic [7:0] on_short, // Per-output on-state short
  input wire logic [7:0] off_open_load, // Per-output off-state open load
  output logic [7:0] out_drive // Gate drive per output
);
  if (N_OUT != osw_pkg::NUM_OUT)
  begin : g_bad_width
    $error("osw_fault_logic supports exactly eight outputs");
  end

  ////////////////////////////////////////////////////////////////
  // Core-clock state
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] stat;
    logic [7:0] hold;
    logic cs_prev;
  } osw_core_t;

  // Link state: frame counter cleared whenever select is high
  typedef struct packed {
    logic [3:0] cnt;
  } osw_frame_t;

  typedef struct packed {
    logic [7:0] shift;
    logic byte_ok;
  } osw_shift_t;

  osw_core_t c_q, c_d;
  osw_frame_t f_q, f_d;
  osw_shift_t s_q, s_d;
  logic do_q;
  logic [osw_pkg::SYNC_W-1:0] sy;
  logic cs_s, en_s, pwm5_s, pwm6_s, ov_s;
  logic [7:0] ol_s, sh_s, ot_s, cmd_eff, live;
  logic frame_rst_b;

  ////////////////////////////////////////////////////////////////
  // Pins from outside the core clock domain
  osw_sync3 #(
    .W(osw_pkg::SYNC_W),
    .INIT(osw_pkg::SYNC_INIT)
  ) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .din({over_temp, on_short, off_open_load, power_supply_over_voltage,
          direct_pwm_input_six, direct_pwm_input_five, enable, cs_b}),
    .dout(sy)
  );

  assign cs_s = sy[osw_pkg::SY_CS];
  assign en_s = sy[osw_pkg::SY_EN];
  assign pwm5_s = sy[osw_pkg::SY_PWM5];
  assign pwm6_s = sy[osw_pkg::SY_PWM6];
  assign ov_s = sy[osw_pkg::SY_OV];
  assign ol_s = sy[osw_pkg::SY_OL +: 8];
  assign sh_s = sy[osw_pkg::SY_SH +: 8];
  assign ot_s = sy[osw_pkg::SY_OT +: 8];

  ////////////////////////////////////////////////////////////////
  // Commanded state, direct drive ORed in on outputs five and six
  always_comb
  begin
    cmd_eff = c_q.cmd;
    cmd_eff[osw_pkg::PWM_FIVE_IDX] = c_q.cmd[osw_pkg::PWM_FIVE_IDX] | pwm5_s;
    cmd_eff[osw_pkg::PWM_SIX_IDX] = c_q.cmd[osw_pkg::PWM_SIX_IDX] | pwm6_s;
  end

  // Drive is combinational so overtemp cuts it with no clock involved;
  // clearing of overtemp or overvoltage restores the kept command
  assign out_drive = cmd_eff & {8{en_s & ~ov_s}} & ~over_temp;

  // Fault seen now: open when commanded off, short or overtemp when on
  assign live = {8{en_s}} & ((~cmd_eff & ol_s) | (cmd_eff & (sh_s | ot_s)));

  ////////////////////////////////////////////////////////////////
  // Status latching, capture at select fall, command at select rise
  always_comb
  begin
    c_d = c_q;
    c_d.cs_prev = cs_s;
    c_d.stat = c_q.stat | live;
    if (c_q.cs_prev && !cs_s)
    begin
      // New faults arriving on the capture edge stay latched
      c_d.hold = c_q.stat | live;
      c_d.stat = live;
    end
    if (!c_q.cs_prev && cs_s && s_q.byte_ok)
    begin
      // Link regs are frozen while select is high, so quasi-static
      c_d.cmd = s_q.shift;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      c_q <= '{cmd: osw_pkg::CMD_RST, stat: osw_pkg::STAT_RST,
               hold: osw_pkg::STAT_RST, cs_prev: 1'b1};
    end
    else
    begin
      c_q <= c_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Link side: select high holds the frame counter cleared
  assign frame_rst_b = rst_b & ~cs_b;

  // Counter saturates so long frames keep shifting
  always_comb
  begin
    f_d = f_q;
    if (f_q.cnt != osw_pkg::CNT_FULL)
    begin
      f_d.cnt = f_q.cnt + 4'h1;
    end
  end

  always_ff @(negedge sclk or negedge frame_rst_b)
  begin
    if (!frame_rst_b)
    begin
      f_q <= '{cnt: osw_pkg::CNT_RST};
    end
    else
    begin
      f_q <= f_d;
    end
  end

  // First falling edge shifts from the captured status word
  always_comb
  begin
    s_d = s_q;
    if (!cs_b)
    begin
      s_d.shift = (f_q.cnt == osw_pkg::CNT_RST) ? {c_q.hold[6:0], serial_command_in}
                                                : {s_q.shift[6:0], serial_command_in};
      s_d.byte_ok = (f_q.cnt >= osw_pkg::CNT_LAST);
    end
  end

  always_ff @(negedge sclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_q <= '{shift: osw_pkg::CMD_RST, byte_ok: 1'b0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Rising edges present msb first; later bits echo received data
  always_ff @(posedge sclk or negedge frame_rst_b)
  begin
    if (!frame_rst_b)
    begin
      do_q <= 1'b0;
    end
    else
    begin
      do_q <= (f_q.cnt == osw_pkg::CNT_RST) ? c_q.hold[7] : s_q.shift[7];
    end
  end

  assign serial_data_out = do_q;
  assign serial_data_out_oe = ~cs_b;

  ////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_cs_rise;
    !c_q.cs_prev && cs_s;
  endsequence

  sequence s_cs_fall;
    c_q.cs_prev && !cs_s;
  endsequence

  a_ovr_all_off: assert property (ov_s |-> out_drive == 8'h00)
    else $error("drive active during overvoltage");
  a_ot_cuts_out: assert property ((over_temp & out_drive) == 8'h00)
    else $error("overtemp output still driven");
  a_en_low_off: assert property (!en_s |-> out_drive == 8'h00 && live == 8'h00)
    else $error("drive or detection while disabled");
  a_cmd_kept_idle: assert property (!en_s && cs_s && c_q.cs_prev |=> $stable(c_q.cmd))
    else $error("command lost while disabled");
  a_cmd_on_rise: assert property (s_cs_rise and s_q.byte_ok |=> c_q.cmd == $past(s_q.shift))
    else $error("command not applied at select rise");
  a_short_frame: assert property (s_cs_rise and !s_q.byte_ok |=> $stable(c_q.cmd))
    else $error("short frame changed command");
  a_stat_capture: assert property (s_cs_fall |=> c_q.hold == $past(c_q.stat | live))
    else $error("status not captured at select fall");
  a_stat_set_wins: assert property (live != 8'h00 |=> (c_q.stat & $past(live)) == $past(live))
    else $error("fault not latched");
  a_pwm5_drives: assert property (pwm5_s && en_s && !ov_s && !over_temp[4] |-> out_drive[4])
    else $error("direct input five not driving");
  a_ot_restart: assert property (c_q.cmd[0] && en_s && !ov_s && $fell(over_temp[0]) |-> out_drive[0])
    else $error("output not restored after overtemp");
  a_do_first_bit: assert property (@(posedge sclk) disable iff (!frame_rst_b)
    f_q.cnt == osw_pkg::CNT_RST |=> do_q == $past(c_q.hold[7]))
    else $error("first serial bit is not output eight status");
endmodule : osw_fault_logic

// ===== dv/osw_host.sv
`timescale 1ns/100ps
module osw_host (
  output logic sclk, // Link clock, low outside frames
  output logic cs_b, // Chip select, active low
  output logic di, // Command bits to the device
  input wire logic dout, // Status bits from the device
  input wire logic dout_oe // Device drive enable
);
  time last_t;
  int oe_miss;
  // Just over the minimum spacing of command writes
  localparam int WR_GAP_NS = osw_pkg::WRITE_GAP_US * 1000 + 100;
  // Idle link: clock low, deselected
  initial
  begin
    sclk = 1'b0;
    cs_b = 1'b1;
    di = 1'b0;
    last_t = 0;
    oe_miss = 0;
  end
  // One transfer of n bits, msb first, 48 ns link period
  task automatic frame(input int n, input logic [15:0] tx, output logic [15:0] rx);
    if ($time < last_t + WR_GAP_NS)
      #(last_t + WR_GAP_NS - $time);
    last_t = $time;
    rx = 16'h0000;
    cs_b = 1'b0;
    // Status capture crosses the core synchroniser first
    #600;
    for (int i = n - 1; i >= 0; i--)
    begin
      sclk = 1'b1;
      di = tx[i];
      #24;
      sclk = 1'b0;
      // Undriven line reads inverted, so a dropped enable shows up
      rx = {rx[14:0], dout_oe ? dout : ~dout};
      if (dout_oe !== 1'b1)
        oe_miss++;
      #24;
    end
    cs_b = 1'b1;
    di = ~di; // Released line must not keep its last value
    #600;
  endtask : frame
endmodule : osw_host

// ===== dv/tb_top.sv
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module tb_top;
  logic clk, rst_b, enable, pwm5, pwm6, ov, sclk, cs_b, di, dout, dout_oe;
  logic [7:0] ot, sh, ol, drv, cmd, exp_st, r;
  logic [15:0] rx, tx;
  logic [31:0] seed;
  int miscompares, num_checks;
  // Core clock, 100 ns
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  osw_fault_logic i_dut (.clk(clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .serial_command_in(di),
    .serial_data_out(dout), .serial_data_out_oe(dout_oe), .enable(enable), .direct_pwm_input_five(pwm5),
    .direct_pwm_input_six(pwm6), .power_supply_over_voltage(ov), .over_temp(ot), .on_short(sh),
    .off_open_load(ol), .out_drive(drv));
  osw_host i_host (.sclk(sclk), .cs_b(cs_b), .di(di), .dout(dout), .dout_oe(dout_oe));
  ////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd8();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction : rnd8
  // Outputs 5 and 6 also follow their direct pins
  function automatic logic [7:0] exp_drv(logic [7:0] c, logic [7:0] t);
    return (enable && !ov) ? ((c | {2'b00, pwm6, pwm5, 4'h0}) & ~t) : 8'h00;
  endfunction : exp_drv
  // Off bit: open load; on bit: short or overtemp
  function automatic logic [7:0] exp_stat(logic [7:0] c);
    return (~c & ol) | (c & (sh | ot));
  endfunction : exp_stat
  task automatic wclk(int n);
    repeat (n) @(posedge clk);
  endtask : wclk
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////////
  // Hang guard: fifteen frames 300 us apart need some 4.5 ms
  initial
  begin
    #7000000;
    miscompares++;
    finish_test();
  end
  // Main sequence
  initial
  begin
    seed = 32'h21a5;
    {rst_b, enable, pwm5, pwm6, ov, ot, sh, ol, cmd, exp_st} = '0;
    wclk(4);
    rst_b <= 1'b1;
    wclk(2);
    `CHK(drv, 8'h00)
    enable <= 1'b1;
    wclk(8);
    // Faults are removed before each frame, so status relies on latching
    for (int n = 0; n < 12; n++)
    begin
      cmd = rnd8();
      i_host.frame(8, {8'h00, cmd}, rx);
      `CHK(rx[7:0], exp_st)
      wclk(10);
      `CHK(drv, exp_drv(cmd, 8'h00))
      r = rnd8();
      // Pulses on odd passes only, 600 us apart, keep the rate under 2 kHz
      pwm5 <= r[0] & ~cmd[4] & n[0];
      pwm6 <= r[1] & ~cmd[5] & n[0];
      wclk(8);
      `CHK(drv, exp_drv(cmd, 8'h00))
      {pwm5, pwm6} <= 2'b00;
      wclk(8);
      ot <= rnd8();
      sh <= rnd8();
      ol <= rnd8();
      #1;
      `CHK(drv, exp_drv(cmd, ot))
      wclk(10);
      exp_st = exp_stat(cmd);
      {ot, sh, ol} <= 24'h0;
      wclk(8);
      `CHK(drv, exp_drv(cmd, 8'h00))
    end
    // Every enable and overvoltage combination, then restore
    for (int k = 0; k < 5; k++)
    begin
      {ov, enable} <= (k == 4) ? 2'b01 : 2'(k);
      wclk(8);
      `CHK(drv, exp_drv(cmd, 8'h00))
    end
    // Sixteen-bit link check, then a short frame that must be dropped
    tx = {rnd8(), rnd8()};
    i_host.frame(16, tx, rx);
    `CHK(rx, {exp_st, tx[15:8]})
    cmd = tx[7:0];
    wclk(10);
    `CHK(drv, exp_drv(cmd, 8'h00))
    i_host.frame(5, 16'h0015, rx);
    wclk(10);
    `CHK(drv, exp_drv(cmd, 8'h00))
    `CHK({dout_oe, dout}, 2'b00)
    // Reset in mid-run clears command and status
    ol <= 8'hff;
    wclk(6);
    rst_b <= 1'b0;
    ol <= 8'h00;
    wclk(2);
    `CHK(drv, 8'h00)
    rst_b <= 1'b1;
    wclk(10);
    `CHK(drv, 8'h00)
    i_host.frame(8, 16'h0000, rx);
    `CHK(rx[7:0], 8'h00)
    wclk(10);
    `CHK(drv, 8'h00)
    `CHK(i_host.oe_miss, 0)
    // Sleep entry: all off commanded, inputs low, then logic supply gone
    {enable, pwm5, pwm6, ov, ot, sh, ol} <= '0;
    wclk(8);
    rst_b <= 1'b0;
    wclk(2);
    `CHK({drv, dout_oe}, 9'h000)
    finish_test();
  end
endmodule : tb_top
